// ===== pcs_defines.svh
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// Register indices; byte address is four times the index
`define PCS_IDX_SLEEP_WAKE 8'hd6
`define PCS_IDX_SOFT_RESET 8'hd8
`define PCS_IDX_BASIC_CTL 8'he4
`define PCS_IDX_BASIC_STAT 8'he6
`define PCS_IDX_IDENT_LOW 8'he8
`define PCS_IDX_IDENT_HIGH 8'hea

// Sleep/wake interval fields and reset values
`define PCS_WAKE_MSB 15
`define PCS_WAKE_LSB 8
`define PCS_SLEEP_MSB 7
`define PCS_SLEEP_LSB 0
`define PCS_WAKE_RST 8'h08
`define PCS_SLEEP_RST 8'h0c

// Basic control field positions
`define PCS_CTL_LOOP 14
`define PCS_CTL_SPEED 13
`define PCS_CTL_ANEN 12
`define PCS_CTL_ANRST 9
`define PCS_CTL_DUPLEX 8
`define PCS_CTL_ALTX 5
`define PCS_CTL_FMDIX 4
`define PCS_CTL_DMDIX 3
`define PCS_CTL_DISTX 1
`define PCS_CTL_DISLED 0

// Port control alias positions
`define PCS_PC_SPEED 6
`define PCS_PC_ANEN 7
`define PCS_PC_ANRST 13
`define PCS_PC_DUPLEX 5
`define PCS_PC_FMDIX 9
`define PCS_PC_DMDIX 10
`define PCS_PC_DISTX 14
`define PCS_PC_DISLED 15

// Soft reset strobe bit and energy-detect mode code
`define PCS_RST_BIT 0
`define PCS_PM_ENERGY 2'b01

// Interval units and clock rate
`define PCS_CLK_MHZ 100
`define PCS_WAKE_UNIT_MS 16
`define PCS_SLEEP_UNIT_MS 1000
`define PCS_WAKE_UNIT_CYC (`PCS_WAKE_UNIT_MS * 1000 * `PCS_CLK_MHZ)
`define PCS_SLEEP_UNIT_CYC (`PCS_SLEEP_UNIT_MS * 1000 * `PCS_CLK_MHZ)

// AXI responses
`define PCS_RESP_OKAY 2'b00
`define PCS_RESP_SLVERR 2'b10

`endif

// ===== pcs_pkg.sv
package pcs_pkg;

    // Register selected by an address
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_SLEEP_WAKE = 3'b001,
        SEL_SOFT_RESET = 3'b010,
        SEL_BASIC_CTL = 3'b011,
        SEL_BASIC_STAT = 3'b100,
        SEL_IDENT_LOW = 3'b101,
        SEL_IDENT_HIGH = 3'b110
    } pcs_sel_t;

    // Power state in energy-detect operation
    typedef enum logic [0:0] {
        PWR_NORMAL = 1'b0,
        PWR_LOW = 1'b1
    } pcs_pwr_t;

endpackage : pcs_pkg

// ===== pcs_regs.sv
`timescale 1ns/100ps
`include "pcs_defines.svh"

// How it works
// - Wake field, bits 15-8, sets energy-present time before waking, 16 ms units.
// - Wake field resets to 0x08, that is 128 ms.
// - Sleep field, bits 7-0, sets no-energy time before sleeping, 1 s units.
// - Sleep field resets to 0x0c, that is 12 seconds.
// - Writing one to reset bit 0 pulses PHY reset; bit reads back zero.
// - Control bit 14 loops host transmit back to host receive.
// - Control bit 13 forces 100 Mbps when set, 10 when clear; resets one.
// - Control bit 12 enables auto-negotiation; resets one.
// - Control bit 9 restarts auto-negotiation; resets zero.
// - Control bit 8 forces full duplex when negotiation is off or failed.
// - Control bit 5 picks alternate crossover algorithm when set; resets one.
// - Bit 4 forces crossed wiring, bit 3 disables auto crossover; both reset zero.
// - Control bit 1 disables transmit, shared with port control bit 14.
// - Control bit 0 turns all LEDs off.
// - Negotiation, speed, duplex, force/disable crossover, restart bits share port control storage.
// - Status bits 14-11 read one, bit 15 reads zero.
// - Status bit 5 shows negotiation complete.
// - Status bit 3 reads one; bits 6 and 0 read zero.
// - Two read-only 16-bit identifier words, low and high.
// - Sleep and wake timing run only in power mode 01.
// - Automatic wake needs the auto wake-up enable bit.

module pcs_regs
    import pcs_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int WAKE_TICK_CYC = `PCS_WAKE_UNIT_CYC,
    parameter int SLEEP_TICK_CYC = `PCS_SLEEP_UNIT_CYC,
    parameter logic [15:0] IDENT_LOW = 16'h5a5a, // Arbitrary value
    parameter logic [15:0] IDENT_HIGH = 16'h00a5 // Arbitrary value
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] portCtlWrData,
    input wire logic portCtlWrEn,
    output logic [15:0] portCtlView,
    input wire logic [1:0] pmMode,
    input wire logic autoWakeEn,
    input wire logic energyPin,
    input wire logic anComplete,
    input wire logic linkUp,
    output logic phySoftReset,
    output logic hostLoopback,
    output logic force100,
    output logic autonegEn,
    output logic autonegRestart,
    output logic forceFull,
    output logic altCrossoverSelect,
    output logic forceMdix,
    output logic disableMdix,
    output logic disableTx,
    output logic disableLed,
    output logic lowPower
);

    // ****************************************
    // Address decode
    // ****************************************

    // Word index from a byte address
    function automatic pcs_sel_t decodeSel(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'b00 || addr[ADDR_W-1:10] != '0) begin
            decodeSel = SEL_NONE;
        end else if (idx == `PCS_IDX_SLEEP_WAKE) begin
            decodeSel = SEL_SLEEP_WAKE;
        end else if (idx == `PCS_IDX_SOFT_RESET) begin
            decodeSel = SEL_SOFT_RESET;
        end else if (idx == `PCS_IDX_BASIC_CTL) begin
            decodeSel = SEL_BASIC_CTL;
        end else if (idx == `PCS_IDX_BASIC_STAT) begin
            decodeSel = SEL_BASIC_STAT;
        end else if (idx == `PCS_IDX_IDENT_LOW) begin
            decodeSel = SEL_IDENT_LOW;
        end else if (idx == `PCS_IDX_IDENT_HIGH) begin
            decodeSel = SEL_IDENT_HIGH;
        end else begin
            decodeSel = SEL_NONE;
        end
    endfunction : decodeSel

    // ****************************************
    // Write channel
    // ****************************************

    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wrFire;
    pcs_sel_t wrSel;
    logic [15:0] wrMask;
    logic [15:0] wrVal;

    // Address and data taken together; one write outstanding
    assign wrFire = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_awready = wrFire;
    assign s_axi_wready = wrFire;
    assign wrSel = decodeSel(s_axi_awaddr);
    assign wrMask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign wrVal = s_axi_wdata[15:0];

    // Response held until bready
    always_ff @(posedge clk) begin
        if (srst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `PCS_RESP_OKAY;
        end else if (ce) begin
            if (wrFire) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wrSel == SEL_NONE) ? `PCS_RESP_SLVERR : `PCS_RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ****************************************
    // Interval register
    // ****************************************

    logic [7:0] wakeIvl_q;
    logic [7:0] sleepIvl_q;

    // Zero is not guarded; software keeps it out
    always_ff @(posedge clk) begin
        if (srst) begin
            wakeIvl_q <= `PCS_WAKE_RST;
            sleepIvl_q <= `PCS_SLEEP_RST;
        end else if (ce && wrFire && wrSel == SEL_SLEEP_WAKE) begin
            if (wrMask[`PCS_WAKE_LSB]) begin
                wakeIvl_q <= wrVal[`PCS_WAKE_MSB:`PCS_WAKE_LSB];
            end
            if (wrMask[`PCS_SLEEP_LSB]) begin
                sleepIvl_q <= wrVal[`PCS_SLEEP_MSB:`PCS_SLEEP_LSB];
            end
        end
    end

    // ****************************************
    // PHY soft reset strobe
    // ****************************************

    logic phyRst_q;

    // One-cycle pulse, nothing stored to read back
    always_ff @(posedge clk) begin
        if (srst) begin
            phyRst_q <= 1'b0;
        end else if (ce) begin
            phyRst_q <= wrFire && wrSel == SEL_SOFT_RESET
                && wrMask[`PCS_RST_BIT] && wrVal[`PCS_RST_BIT];
        end
    end

    assign phySoftReset = phyRst_q;

    // ****************************************
    // Basic control, shared with port control
    // ****************************************

    logic loop_q;
    logic speed_q;
    logic anEn_q;
    logic anRst_q;
    logic duplex_q;
    logic altX_q;
    logic fMdix_q;
    logic dMdix_q;
    logic disTx_q;
    logic disLed_q;
    logic ctlHi;
    logic ctlLo;

    assign ctlHi = wrFire && wrSel == SEL_BASIC_CTL && wrMask[8];
    assign ctlLo = wrFire && wrSel == SEL_BASIC_CTL && wrMask[0];

    // Port side written last, so it wins a same-cycle clash
    always_ff @(posedge clk) begin
        if (srst) begin
            loop_q <= 1'b0;
            speed_q <= 1'b1;
            anEn_q <= 1'b1;
            anRst_q <= 1'b0;
            duplex_q <= 1'b1;
            altX_q <= 1'b1;
            fMdix_q <= 1'b0;
            dMdix_q <= 1'b0;
            disTx_q <= 1'b0;
            disLed_q <= 1'b0;
        end else if (ce) begin
            if (ctlHi) begin
                loop_q <= wrVal[`PCS_CTL_LOOP];
                speed_q <= wrVal[`PCS_CTL_SPEED];
                anEn_q <= wrVal[`PCS_CTL_ANEN];
                anRst_q <= wrVal[`PCS_CTL_ANRST];
                duplex_q <= wrVal[`PCS_CTL_DUPLEX];
            end
            if (ctlLo) begin
                altX_q <= wrVal[`PCS_CTL_ALTX];
                fMdix_q <= wrVal[`PCS_CTL_FMDIX];
                dMdix_q <= wrVal[`PCS_CTL_DMDIX];
                disTx_q <= wrVal[`PCS_CTL_DISTX];
                disLed_q <= wrVal[`PCS_CTL_DISLED];
            end
            if (portCtlWrEn) begin
                speed_q <= portCtlWrData[`PCS_PC_SPEED];
                anEn_q <= portCtlWrData[`PCS_PC_ANEN];
                anRst_q <= portCtlWrData[`PCS_PC_ANRST];
                duplex_q <= portCtlWrData[`PCS_PC_DUPLEX];
                fMdix_q <= portCtlWrData[`PCS_PC_FMDIX];
                dMdix_q <= portCtlWrData[`PCS_PC_DMDIX];
                disTx_q <= portCtlWrData[`PCS_PC_DISTX];
                disLed_q <= portCtlWrData[`PCS_PC_DISLED];
            end
        end
    end

    // Shared bits seen from the port control side
    always_comb begin
        portCtlView = 16'h0000;
        portCtlView[`PCS_PC_SPEED] = speed_q;
        portCtlView[`PCS_PC_ANEN] = anEn_q;
        portCtlView[`PCS_PC_ANRST] = anRst_q;
        portCtlView[`PCS_PC_DUPLEX] = duplex_q;
        portCtlView[`PCS_PC_FMDIX] = fMdix_q;
        portCtlView[`PCS_PC_DMDIX] = dMdix_q;
        portCtlView[`PCS_PC_DISTX] = disTx_q;
        portCtlView[`PCS_PC_DISLED] = disLed_q;
    end

    assign hostLoopback = loop_q;
    assign force100 = speed_q;
    assign autonegEn = anEn_q;
    assign autonegRestart = anRst_q;
    assign forceFull = duplex_q;
    assign altCrossoverSelect = altX_q;
    assign forceMdix = fMdix_q;
    assign disableMdix = dMdix_q;
    assign disableTx = disTx_q;
    assign disableLed = disLed_q;

    // ****************************************
    // Read channel
    // ****************************************

    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic rdFire;
    pcs_sel_t rdSel;
    logic [15:0] ctlWord;
    logic [15:0] statWord;
    logic [15:0] rdWord;

    assign rdFire = ce && s_axi_arvalid && !rvalid_q;
    assign s_axi_arready = rdFire;
    assign rdSel = decodeSel(s_axi_araddr);

    // Control word; reserved bits read zero
    always_comb begin
        ctlWord = 16'h0000;
        ctlWord[`PCS_CTL_LOOP] = loop_q;
        ctlWord[`PCS_CTL_SPEED] = speed_q;
        ctlWord[`PCS_CTL_ANEN] = anEn_q;
        ctlWord[`PCS_CTL_ANRST] = anRst_q;
        ctlWord[`PCS_CTL_DUPLEX] = duplex_q;
        ctlWord[`PCS_CTL_ALTX] = altX_q;
        ctlWord[`PCS_CTL_FMDIX] = fMdix_q;
        ctlWord[`PCS_CTL_DMDIX] = dMdix_q;
        ctlWord[`PCS_CTL_DISTX] = disTx_q;
        ctlWord[`PCS_CTL_DISLED] = disLed_q;
    end

    // Fixed abilities plus live negotiation and link
    assign statWord = {1'b0, 4'hf, 4'h0, 1'b0,
        anComplete, 1'b0, 1'b1, linkUp, 2'b00};

    // Read mux
    always_comb begin
        if (rdSel == SEL_SLEEP_WAKE) begin
            rdWord = {wakeIvl_q, sleepIvl_q};
        end else if (rdSel == SEL_BASIC_CTL) begin
            rdWord = ctlWord;
        end else if (rdSel == SEL_BASIC_STAT) begin
            rdWord = statWord;
        end else if (rdSel == SEL_IDENT_LOW) begin
            rdWord = IDENT_LOW;
        end else if (rdSel == SEL_IDENT_HIGH) begin
            rdWord = IDENT_HIGH;
        end else begin
            rdWord = 16'h0000; // Reset strobe is write-only
        end
    end

    // Data registered; held until rready
    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rresp_q <= `PCS_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            if (rdFire) begin
                rvalid_q <= 1'b1;
                rresp_q <= (rdSel == SEL_NONE) ? `PCS_RESP_SLVERR : `PCS_RESP_OKAY;
                rdata_q <= {16'h0000, rdWord};
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // ****************************************
    // Energy-detect power timing
    // ****************************************

    logic energyMeta_q;
    logic energy_q;

    // Energy pin is asynchronous to clk
    always_ff @(posedge clk) begin
        if (srst) begin
            energyMeta_q <= 1'b0;
            energy_q <= 1'b0;
        end else if (ce) begin
            energyMeta_q <= energyPin;
            energy_q <= energyMeta_q;
        end
    end

    pcs_pwr_t pwr_q;
    logic [31:0] preCnt_q;
    logic [7:0] unitCnt_q;
    logic edMode;
    logic watching;
    logic tickLen;
    logic [7:0] target;
    logic [31:0] preMax;

    assign edMode = (pmMode == `PCS_PM_ENERGY);
    // Awake: watch for silence; asleep: watch for energy if allowed
    assign watching = edMode && ((pwr_q == PWR_NORMAL && !energy_q)
        || (pwr_q == PWR_LOW && energy_q && autoWakeEn));
    assign tickLen = (pwr_q == PWR_LOW);
    assign preMax = tickLen ? 32'(WAKE_TICK_CYC - 1) : 32'(SLEEP_TICK_CYC - 1);
    assign target = tickLen ? wakeIvl_q : sleepIvl_q;

    // Prescaler and unit count restart when the run breaks
    always_ff @(posedge clk) begin
        if (srst) begin
            preCnt_q <= 32'h0000_0000;
            unitCnt_q <= 8'h00;
        end else if (ce) begin
            if (!watching || unitCnt_q == target) begin
                preCnt_q <= 32'h0000_0000;
                unitCnt_q <= 8'h00;
            end else if (preCnt_q == preMax) begin
                preCnt_q <= 32'h0000_0000;
                unitCnt_q <= unitCnt_q + 8'h01;
            end else begin
                preCnt_q <= preCnt_q + 32'h0000_0001;
            end
        end
    end

    // Power state; leaving the mode returns to normal
    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_q <= PWR_NORMAL;
        end else if (ce) begin
            if (!edMode) begin
                pwr_q <= PWR_NORMAL;
            end else if (watching && unitCnt_q == target) begin
                case (pwr_q)
                    PWR_NORMAL: begin
                        pwr_q <= PWR_LOW;
                    end
                    PWR_LOW: begin
                        pwr_q <= PWR_NORMAL;
                    end
                    default: begin
                        pwr_q <= PWR_NORMAL;
                    end
                endcase
            end
        end
    end

    assign lowPower = (pwr_q == PWR_LOW);

endmodule : pcs_regs

// ===== pcs_regs_sva.sv
`timescale 1ns/100ps
`include "pcs_defines.svh"
// ****
// Bus answer and power state checks
// ****
module pcs_regs_sva
    import pcs_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [1:0] pmMode,
    input wire logic autoWakeEn,
    input wire logic phySoftReset,
    input wire logic lowPower
);
    logic wrAcc, rdAcc;
    logic rstWr_q;
    logic [ADDR_W-1:0] rdAddr_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Acceptance as the bus sees it
    assign wrAcc = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && ce;
    assign rdAcc = s_axi_arvalid && !s_axi_rvalid && ce;

    // Remember the strobe write and the read target
    always_ff @(posedge clk) begin
        if (srst) begin
            rstWr_q <= 1'b0;
            rdAddr_q <= '0;
        end else if (ce) begin
            rstWr_q <= wrAcc && s_axi_awaddr == ADDR_W'(`PCS_IDX_SOFT_RESET * 4)
                && s_axi_wdata[0] && s_axi_wstrb[0];
            if (rdAcc) begin
                rdAddr_q <= s_axi_araddr;
            end
        end
    end

    a_write_answer: assert property (wrAcc |=> s_axi_bvalid)
        else $error("write not answered next cycle");
    a_read_answer: assert property (rdAcc |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped early");
    a_strobe_width: assert property (rstWr_q |-> phySoftReset ##1 !phySoftReset)
        else $error("soft reset pulse wrong");
    a_strobe_cause: assert property (phySoftReset |-> rstWr_q)
        else $error("soft reset without write");
    a_status_fixed: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 && rdAddr_q ==
        ADDR_W'(`PCS_IDX_BASIC_STAT * 4) |-> (s_axi_rdata[15:0] & 16'hf849) == 16'h7808)
        else $error("fixed status bits wrong");
    a_sleep_mode: assert property ($rose(lowPower) |-> $past(pmMode) == `PCS_PM_ENERGY)
        else $error("low power outside energy mode");
    a_mode_exit: assert property (lowPower && pmMode != 2'h1 |=> !lowPower)
        else $error("low power kept after mode exit");
    a_wake_enable: assert property ($fell(lowPower) |-> $past(pmMode) != 2'h1
        || $past(autoWakeEn)) else $error("woke without auto wake");

    c_strobe: cover property (rstWr_q);
    c_sleep: cover property ($rose(lowPower));
    c_wake: cover property ($fell(lowPower));
endmodule : pcs_regs_sva

bind pcs_regs pcs_regs_sva #(.ADDR_W(ADDR_W)) i_pcs_regs_sva (.clk(clk), .srst(srst),
    .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .pmMode(pmMode),
    .autoWakeEn(autoWakeEn), .phySoftReset(phySoftReset), .lowPower(lowPower));

// ===== tb_pcs_regs.sv
`timescale 1ns/100ps
// ****
// Register bench
// ****
module tb_pcs_regs
    import pcs_pkg::*;
;
    localparam logic [15:0] IDL = 16'h3c3c; // Arbitrary value
    localparam logic [15:0] IDH = 16'h00c3; // Arbitrary value
    logic clk, srst, ce, awValid, wValid, bReady, arValid, rReady, portWrEn;
    logic autoWakeEn, energyPin, anComplete, linkUp, phySoftReset, lowPower;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [11:0] awAddr, arAddr;
    logic [31:0] wData, rData;
    logic [3:0] wStrb;
    logic [1:0] bResp, rResp, pmMode;
    logic [15:0] portData, portView;
    logic [9:0] ctl;
    int fails = 0, checked = 0, cycles = 0, pulses = 0;

    pcs_regs #(.WAKE_TICK_CYC(4), .SLEEP_TICK_CYC(10), .IDENT_LOW(IDL), .IDENT_HIGH(IDH))
    i_pcs_regs (.clk(clk), .srst(srst), .ce(ce), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .portCtlWrData(portData), .portCtlWrEn(portWrEn), .portCtlView(portView),
        .pmMode(pmMode), .autoWakeEn(autoWakeEn), .energyPin(energyPin),
        .anComplete(anComplete), .linkUp(linkUp), .phySoftReset(phySoftReset),
        .hostLoopback(ctl[9]), .force100(ctl[8]), .autonegEn(ctl[7]), .autonegRestart(ctl[6]),
        .forceFull(ctl[5]), .altCrossoverSelect(ctl[4]), .forceMdix(ctl[3]),
        .disableMdix(ctl[2]), .disableTx(ctl[1]), .disableLed(ctl[0]), .lowPower(lowPower));

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard and strobe pulse count
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (phySoftReset === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    task stop_test;
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask : chk

    // Bus write; valids held until taken
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        @(posedge clk);
        awAddr <= a;
        wData <= d;
        wStrb <= s;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        #1;
        while (!(awReady && wReady)) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        awValid <= 1'b0;
        wValid <= 1'b0;
        #1;
        while (!bValid) begin
            @(posedge clk);
            #1;
        end
        r = bResp;
        @(posedge clk);
        bReady <= 1'b0;
    endtask : wr

    // Bus read; stall holds the clock enable low first
    task rd(input logic [11:0] a, input int stall, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        if (stall > 0) begin
            ce <= 1'b0;
            repeat (stall) @(posedge clk);
            ce <= 1'b1;
            chk(rValid, 0, "read taken while stalled");
        end
        #1;
        while (!arReady) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        arValid <= 1'b0;
        #1;
        while (!rValid) begin
            @(posedge clk);
            #1;
        end
        d = rData;
        r = rResp;
        @(posedge clk);
        rReady <= 1'b0;
    endtask : rd

    task wrok(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, 4'hf, r);
        chk(r, 2'h0, "write response");
    endtask : wrok

    task rdchk(input logic [11:0] a, input logic [15:0] e, input string m);
        logic [1:0] r;
        logic [31:0] d;
        rd(a, 0, d, r);
        chk(r, 2'h0, "read response");
        chk(d, {16'h0000, e}, m);
    endtask : rdchk

    function automatic logic [9:0] ctlExp(input logic [15:0] v);
        return {v[14], v[13], v[12], v[9], v[8], v[5], v[4], v[3], v[1], v[0]};
    endfunction : ctlExp

    // Shared bits as the port control register places them
    function automatic logic [15:0] viewExp(input logic [15:0] v);
        return {v[0], v[1], v[9], 2'h0, v[3], v[4], 1'b0, v[12], v[13], v[8], 5'h00};
    endfunction : viewExp

    task t_reset;
        chk({ctl, lowPower, phySoftReset}, 12'h6c0, "reset outputs");
        rdchk(12'h358, 16'h080c, "interval reset");
        rdchk(12'h390, 16'h3120, "control reset");
    endtask : t_reset

    // Walking one, then all ones, through the control word
    task t_control;
        logic [15:0] v;
        for (int i = 0; i <= 16; i++) begin
            v = (i == 16) ? 16'hffff : 16'h0001 << i;
            wrok(12'h390, {16'h0000, v});
            chk(ctl, ctlExp(v), "control outputs");
            chk(portView, viewExp(v), "port view");
            rdchk(12'h390, v & 16'h733b, "control readback");
        end
    endtask : t_control

    task t_port;
        wrok(12'h390, 32'h0000_0000);
        @(posedge clk);
        portData <= 16'hffff;
        portWrEn <= 1'b1;
        @(posedge clk);
        portWrEn <= 1'b0;
        rdchk(12'h390, 16'h331b, "port write seen in control");
        chk(ctl, ctlExp(16'h331b), "port write outputs");
    endtask : t_port

    task t_strobe;
        int p;
        logic [1:0] r;
        p = pulses;
        wrok(12'h360, 32'h0000_0001);
        #1;
        chk(pulses - p, 1, "one reset pulse");
        wr(12'h360, 32'h0000_0001, 4'h2, r);
        #1;
        chk(pulses - p, 1, "pulse with lane off");
        rdchk(12'h360, 16'h0000, "reset bit reads zero");
    endtask : t_strobe

    task t_status;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            anComplete <= i[1];
            linkUp <= i[0];
            rdchk(12'h398, 16'h7808 | {10'h000, i[1], 2'h0, i[0], 2'h0}, "status");
        end
    endtask : t_status

    task t_ident;
        logic [1:0] r;
        wr(12'h3a0, 32'h0000_ffff, 4'hf, r);
        rdchk(12'h3a0, IDL, "ident low");
        rdchk(12'h3a8, IDH, "ident high");
    endtask : t_ident

    task t_unmapped;
        logic [1:0] r;
        logic [31:0] d;
        rd(12'h3fc, 0, d, r);
        chk({r, d}, {2'h2, 32'h0}, "unmapped read");
        rd(12'h35a, 0, d, r);
        chk({r, d}, {2'h2, 32'h0}, "misaligned read");
        wr(12'h3fc, 32'h0, 4'hf, r);
        chk(r, 2'h2, "unmapped write");
    endtask : t_unmapped

    task waitPow(input logic lvl, output int n);
        n = 0;
        while (lowPower !== lvl && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : waitPow

    // Sleep 2 units of 10, wake 3 units of 4
    task t_intervals;
        logic [1:0] r;
        logic [31:0] d;
        int n;
        wr(12'h358, 32'h0000_aa55, 4'h2, r);
        rdchk(12'h358, 16'haa0c, "upper lane only");
        wrok(12'h358, 32'h0000_0302);
        rd(12'h358, 3, d, r);
        chk(d, 32'h0000_0302, "stalled read");
        energyPin <= 1'b0;
        repeat (40) @(posedge clk);
        chk(lowPower, 0, "slept outside mode");
        pmMode <= 2'h1;
        waitPow(1'b1, n);
        chk(n >= 19 && n <= 24, 1, "go-sleep time");
        energyPin <= 1'b1;
        repeat (30) @(posedge clk);
        chk(lowPower, 1, "woke without enable");
        energyPin <= 1'b0;
        autoWakeEn <= 1'b1;
        repeat (3) @(posedge clk);
        energyPin <= 1'b1;
        waitPow(1'b0, n);
        chk(n >= 12 && n <= 17, 1, "wake-up time");
        energyPin <= 1'b0;
        waitPow(1'b1, n);
        chk(lowPower, 1, "sleep again");
        pmMode <= 2'h0;
        repeat (2) @(posedge clk);
        chk(lowPower, 0, "mode exit");
    endtask : t_intervals

    // Main sequence
    initial begin
        {srst, ce, energyPin} = 3'h7;
        {awValid, wValid, bReady, arValid, rReady, portWrEn} = 6'h00;
        {autoWakeEn, anComplete, linkUp, pmMode, awAddr, arAddr, wData, wStrb, portData} = '0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_control();
        t_port();
        t_strobe();
        t_status();
        t_ident();
        t_unmapped();
        t_intervals();
        stop_test();
    end
endmodule : tb_pcs_regs
